// ===== nibble_alu_pkg.sv
// Purpose: Shared constants and types for the nibble operation unit
// Assumes: 4-bit data path, 7-bit data memory address
// Notes:   Operation codes are local to this unit
package nibble_alu_pkg;
    localparam int DATA_W     = 4;
    localparam int ADDR_W     = 7;
    localparam int MEM_DEPTH  = 128;
    localparam logic [3:0] ACC_RESET   = 4'h0;
    localparam logic       CARRY_RESET = 1'b0;
    localparam logic [3:0] ONE_NIBBLE  = 4'h1;
    localparam int MSB_POS    = 3;

    // Operation codes seen on the command port
    typedef enum logic [3:0] {
        OP_NONE     = 4'h0,
        OP_INC      = 4'h1,
        OP_DEC      = 4'h2,
        OP_ADC      = 4'h3,
        OP_SBB      = 4'h4,
        OP_ADD      = 4'h5,
        OP_SUB      = 4'h6,
        OP_ADDKEEP  = 4'h7,
        OP_AND      = 4'h8
    } op_e;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_EXEC  = 2'b10
    } state_e;
endpackage : nibble_alu_pkg

// ===== nibble_mem_if.sv
// Purpose: Bundle between the sequencer and the data memory
// Assumes: Single clock, synchronous read
// Notes:   Read data valid one cycle after address
`timescale 1ns/1ns
interface nibble_mem_if;
    logic [nibble_alu_pkg::ADDR_W-1:0] addr;
    logic                              wr_en;
    logic [nibble_alu_pkg::DATA_W-1:0] wr_data;
    logic [nibble_alu_pkg::DATA_W-1:0] rd_data;
    modport ctrl (output addr, output wr_en, output wr_data, input rd_data);
    modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface : nibble_mem_if

// ===== nibble_data_mem.sv
// Purpose: Data memory of nibbles
// Assumes: Synchronous read and write
// Notes:   Contents are not cleared by reset, as in a real RAM
`timescale 1ns/1ns
module nibble_data_mem (
    // Clocking
    input  wire logic clock,
    input  wire logic clk_en,
    // Memory side
    nibble_mem_if.mem m
);
    logic [nibble_alu_pkg::DATA_W-1:0] store [nibble_alu_pkg::MEM_DEPTH];
    logic [nibble_alu_pkg::DATA_W-1:0] rd_ff;

    // Write port
    always_ff @(posedge clock) begin
        if (clk_en && m.wr_en) begin
            store[m.addr] <= m.wr_data;
        end
    end

    // Registered read
    always_ff @(posedge clock) begin
        if (clk_en) begin
            rd_ff <= store[m.addr];
        end
    end

    assign m.rd_data = rd_ff;
endmodule : nibble_data_mem

// ===== nibble_alu_core.sv
// Purpose: Adder and logic stage of the nibble operation unit
// Assumes: Purely combinational
// Notes:   Carry out is bit 4 of a 5-bit sum
`timescale 1ns/1ns
module nibble_alu_core (
    // Operands
    input  wire logic [3:0]                 mem_opnd,
    input  wire logic [3:0]                 acc,
    input  wire logic                       carry_in,
    input  wire nibble_alu_pkg::op_e        op,
    // Results
    output logic      [3:0]                 result,
    output logic                            carry_out,
    output logic                            carry_upd
);
    logic [4:0] sum;

    // Operation select
    always_comb begin
        sum       = 5'h00;
        carry_upd = 1'b1;
        case (op)
            nibble_alu_pkg::OP_INC:  sum = {1'b0, mem_opnd} + {1'b0, nibble_alu_pkg::ONE_NIBBLE};
            nibble_alu_pkg::OP_DEC:  sum = {1'b0, mem_opnd} + 5'h0F; // Carry set when no borrow
            nibble_alu_pkg::OP_ADC:  sum = {1'b0, mem_opnd} + {1'b0, acc} + {4'h0, carry_in};
            nibble_alu_pkg::OP_SBB:  sum = {1'b0, mem_opnd} + {1'b0, ~acc} + {4'h0, carry_in};
            nibble_alu_pkg::OP_ADD:  sum = {1'b0, mem_opnd} + {1'b0, acc};
            nibble_alu_pkg::OP_SUB:  sum = {1'b0, mem_opnd} + {1'b0, ~acc} + 5'h01;
            nibble_alu_pkg::OP_ADDKEEP: begin
                sum       = {1'b0, mem_opnd} + {1'b0, acc};
                carry_upd = 1'b0;
            end
            nibble_alu_pkg::OP_AND: begin
                sum       = {1'b0, mem_opnd & acc};
                carry_upd = 1'b0;
            end
            default: carry_upd = 1'b0;
        endcase
    end

    assign result    = sum[3:0];
    assign carry_out = sum[4];
endmodule : nibble_alu_core

// ===== nibble_alu_operations.sv
// Purpose: Operation instructions of a 4-bit core on memory and the result register
// Assumes: One command at a time, accepted while ready is high
// Notes:   Three cycles per command: address, read, execute
// Operation
// - Increment direct word, write to memory and result register, update carry.
// - Increment pointer-addressed word, write back and to result register, update carry.
// - Decrement direct word, write to memory and result register, update carry.
// - Decrement pointer-addressed word, write back and to result register, update carry.
// - Indirect forms read and write the word addressed by the pointer.
// - Add with carry: memory plus register plus carry into register only.
// - Add with carry write-back stores the sum to register and memory.
// - Subtract with borrow: memory plus inverted register plus carry into register.
// - Subtract with borrow write-back stores to register and memory.
// - Plain add into register only, carry updated.
// - Plain add write-back stores to register and memory, carry updated.
// - Subtract: memory plus inverted register plus one into register only.
// - Subtract write-back stores the difference to register and memory.
// - Add keeping carry: sum into register, carry untouched.
// - Add keeping carry write-back stores to both, carry untouched.
// - AND memory with register into register, direct or indirect.
// - AND write-back stores the AND to register and memory.
// - Memory words, register and operands are four bits, bit 3 is MSB.
`timescale 1ns/1ns
module nibble_alu_operations (
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                srst,
    input  wire logic                                clk_en,
    // Command
    input  wire logic                                cmd_valid,
    output logic                                     cmd_ready,
    input  wire nibble_alu_pkg::op_e                 cmd_op,
    input  wire logic                                cmd_store,
    input  wire logic                                cmd_indirect,
    input  wire logic [nibble_alu_pkg::ADDR_W-1:0]   cmd_addr,
    input  wire logic [nibble_alu_pkg::ADDR_W-1:0]   indirect_pointer,
    // Results
    output logic      [nibble_alu_pkg::DATA_W-1:0]   result_register,
    output logic                                     carry_flag,
    output logic                                     done
);
    nibble_mem_if mif ();

    nibble_alu_pkg::state_e          state_ff;
    nibble_alu_pkg::op_e             op_ff;
    logic                            store_ff;
    logic [nibble_alu_pkg::ADDR_W-1:0] addr_ff;
    logic [3:0]                      acc_ff;
    logic                            carry_ff;
    logic                            done_ff;
    logic [3:0]                      alu_res;
    logic                            alu_carry;
    logic                            alu_upd;
    logic                            exec;

    // Data memory, one word per nibble
    nibble_data_mem u_mem (
        .clock  (clock),
        .clk_en (clk_en),
        .m      (mif.mem)
    );

    // Arithmetic and logic stage
    nibble_alu_core u_core (
        .mem_opnd  (mif.rd_data),
        .acc       (acc_ff),
        .carry_in  (carry_ff),
        .op        (op_ff),
        .result    (alu_res),
        .carry_out (alu_carry),
        .carry_upd (alu_upd)
    );

    assign cmd_ready = (state_ff == nibble_alu_pkg::ST_IDLE);
    assign exec      = (state_ff == nibble_alu_pkg::ST_EXEC);

    // Sequencer; a NONE command is dropped so it never touches memory
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= nibble_alu_pkg::ST_IDLE;
        end else if (clk_en) begin
            case (state_ff)
                nibble_alu_pkg::ST_IDLE: begin
                    if (cmd_valid && cmd_op != nibble_alu_pkg::OP_NONE) begin
                        state_ff <= nibble_alu_pkg::ST_READ;
                    end
                end
                nibble_alu_pkg::ST_READ: state_ff <= nibble_alu_pkg::ST_EXEC;
                nibble_alu_pkg::ST_EXEC: state_ff <= nibble_alu_pkg::ST_IDLE;
                default:                 state_ff <= nibble_alu_pkg::ST_IDLE;
            endcase
        end
    end

    // Command capture; pointer sampled at acceptance
    always_ff @(posedge clock) begin
        if (srst) begin
            op_ff    <= nibble_alu_pkg::OP_NONE;
            store_ff <= 1'b0;
            addr_ff  <= '0;
        end else if (clk_en && cmd_ready && cmd_valid) begin
            op_ff    <= cmd_op;
            // Increment and decrement always write back
            store_ff <= cmd_store || cmd_op == nibble_alu_pkg::OP_INC
                                  || cmd_op == nibble_alu_pkg::OP_DEC;
            addr_ff  <= cmd_indirect ? indirect_pointer : cmd_addr;
        end
    end

    // Memory port: address held through read and execute
    assign mif.addr    = addr_ff;
    // Starred forms write the result back
    assign mif.wr_en   = exec && store_ff;
    assign mif.wr_data = alu_res;

    // Result register loaded on every operation
    always_ff @(posedge clock) begin
        if (srst) begin
            acc_ff <= nibble_alu_pkg::ACC_RESET;
        end else if (clk_en && exec) begin
            acc_ff <= alu_res; // Wraps modulo sixteen
        end
    end

    // Carry from bit 3; kept for add-keep and AND
    always_ff @(posedge clock) begin
        if (srst) begin
            carry_ff <= nibble_alu_pkg::CARRY_RESET;
        end else if (clk_en && exec && alu_upd) begin
            carry_ff <= alu_carry;
        end
    end

    // Completion pulse
    always_ff @(posedge clock) begin
        if (srst) begin
            done_ff <= 1'b0;
        end else if (clk_en) begin
            done_ff <= exec;
        end
    end

    assign result_register = acc_ff;
    assign carry_flag      = carry_ff;
    assign done            = done_ff;
endmodule : nibble_alu_operations

// ===== nibble_alu_operations_props.sv
// Purpose: Port checks on the nibble operation unit
// Assumes: clk_en stays high while commands run
// Notes:   Bound to the top module below
`timescale 1ns/1ns
module nibble_alu_operations_props (
    // Clock and reset
    input wire logic                                clock,
    input wire logic                                srst,
    input wire logic                                clk_en,
    // Command
    input wire logic                                cmd_valid,
    input wire logic                                cmd_ready,
    input wire nibble_alu_pkg::op_e                 cmd_op,
    input wire logic                                cmd_store,
    input wire logic                                cmd_indirect,
    input wire logic [nibble_alu_pkg::ADDR_W-1:0]   cmd_addr,
    input wire logic [nibble_alu_pkg::ADDR_W-1:0]   indirect_pointer,
    // Results
    input wire logic [nibble_alu_pkg::DATA_W-1:0]   result_register,
    input wire logic                                carry_flag,
    input wire logic                                done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Acceptance edge; op code zero is ignored
    wire logic acc_ok = clk_en && cmd_valid && cmd_ready && cmd_op != nibble_alu_pkg::OP_NONE;

    a_ready_busy: assert property (acc_ok |=> !cmd_ready [*2] ##1 cmd_ready)
        else $error("ready not low for exactly two cycles");
    a_done_latency: assert property (acc_ok |-> ##3 done)
        else $error("done late");
    a_done_cause: assert property (done |-> $past(acc_ok, 3) && !$past(done))
        else $error("done without command");
    // Result and carry load at the second edge after acceptance, so a change
    // is first seen in the sampled values one edge later
    a_result_cause: assert property (!$stable(result_register) |-> $past(acc_ok, 3))
        else $error("result changed without command");
    a_carry_cause: assert property (!$stable(carry_flag) |-> $past(acc_ok, 3))
        else $error("carry changed without command");
    a_keep_carry: assert property ($past(acc_ok, 3)
        && $past(cmd_op, 3) >= nibble_alu_pkg::OP_ADDKEEP |-> $stable(carry_flag))
        else $error("carry altered by keep or and");
    a_inc_carry: assert property ($past(acc_ok, 3) && $past(cmd_op, 3) == nibble_alu_pkg::OP_INC
        |-> carry_flag == (result_register == 4'h0))
        else $error("increment carry wrong");
    a_dec_carry: assert property ($past(acc_ok, 3) && $past(cmd_op, 3) == nibble_alu_pkg::OP_DEC
        |-> carry_flag == (result_register != 4'hF))
        else $error("decrement carry wrong");
    a_and_subset: assert property ($past(acc_ok, 3) && $past(cmd_op, 3) == nibble_alu_pkg::OP_AND
        |-> (result_register & ~$past(result_register)) == 4'h0)
        else $error("and set a new bit");
    a_reset_clear: assert property ($fell(srst)
        |-> result_register == 4'h0 && !carry_flag && !done)
        else $error("reset values wrong");
endmodule : nibble_alu_operations_props

bind nibble_alu_operations nibble_alu_operations_props u_props (.clock(clock), .srst(srst),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_store(cmd_store), .cmd_indirect(cmd_indirect), .cmd_addr(cmd_addr),
    .indirect_pointer(indirect_pointer), .result_register(result_register),
    .carry_flag(carry_flag), .done(done));

// ===== test_nibble_alu_operations.sv
// Purpose: Self-checking bench for the nibble operation unit
// Assumes: Memory starts unknown; AND* with a zero register clears a word
// Notes:   A shadow memory tracks write-back, so a lost store shows up later
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin miscompares++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module test_nibble_alu_operations;
    logic clock = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_store = 1'b0, cmd_indirect = 1'b0;
    logic [6:0] cmd_addr = 7'h00, indirect_pointer = 7'h00;
    nibble_alu_pkg::op_e cmd_op = nibble_alu_pkg::OP_NONE;
    logic cmd_ready, carry_flag, done, cf_m = 1'b0;
    logic [3:0] result_register, acc_m = 4'h0;
    logic [3:0] sm [0:127];
    int miscompares = 0, check_count = 0;

    nibble_alu_operations u_nibble_alu_operations (.clock(clock), .srst(srst), .clk_en(1'b1),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_store(cmd_store),
        .cmd_indirect(cmd_indirect), .cmd_addr(cmd_addr), .indirect_pointer(indirect_pointer),
        .result_register(result_register), .carry_flag(carry_flag), .done(done));

    // Clock generator, 20 ns period
    initial begin
        forever #10 clock = ~clock;
    end

    // One command; the unused address field points elsewhere to catch a wrong source
    task automatic do_op(input logic [3:0] op, input logic st, input logic ind,
                         input logic [6:0] a);
        logic [4:0] s;
        int n;
        case (op)
            4'h1: s = {1'b0, sm[a]} + 5'h01;
            4'h2: s = {1'b0, sm[a]} + 5'h0F;
            4'h3: s = {1'b0, sm[a]} + {1'b0, acc_m} + {4'h0, cf_m};
            4'h4: s = {1'b0, sm[a]} + {1'b0, ~acc_m} + {4'h0, cf_m};
            4'h5, 4'h7: s = {1'b0, sm[a]} + {1'b0, acc_m};
            4'h6: s = {1'b0, sm[a]} + {1'b0, ~acc_m} + 5'h01;
            default: s = {1'b0, sm[a] & acc_m};
        endcase
        cmd_op = nibble_alu_pkg::op_e'(op);
        cmd_store = st;
        cmd_indirect = ind;
        cmd_addr = ind ? ~a : a;
        indirect_pointer = ind ? a : ~a;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        `CHK("busy", 1'b0, cmd_ready)
        n = 0;
        while (done !== 1'b1 && n < 8) begin
            @(negedge clock);
            n++;
        end
        acc_m = s[3:0];
        if (op < 4'h7) cf_m = s[4];
        if (st || op < 4'h3) sm[a] = s[3:0];
        // Done is raised by the same edge that loads the result register
        `CHK("latency", 2, n)
        `CHK("ready", 1'b1, cmd_ready)
        `CHK("result", acc_m, result_register)
        `CHK("carry", cf_m, carry_flag)
    endtask : do_op

    // Clear words with AND*, then step through increment and decrement wraps
    task automatic t_build;
        do_op(4'h8, 1'b1, 1'b0, 7'h05);
        do_op(4'h8, 1'b1, 1'b1, 7'h09);
        do_op(4'h2, 1'b0, 1'b0, 7'h09);
        do_op(4'h2, 1'b0, 1'b1, 7'h09);
        do_op(4'h1, 1'b0, 1'b0, 7'h09);
        do_op(4'h1, 1'b0, 1'b1, 7'h09);
        do_op(4'h1, 1'b0, 1'b1, 7'h05);
        do_op(4'h2, 1'b0, 1'b0, 7'h05);
    endtask : t_build

    // A code-zero request is dropped: no pulse, no change, ready stays high
    task automatic t_none;
        cmd_op = nibble_alu_pkg::OP_NONE;
        cmd_valid = 1'b1;
        @(negedge clock);
        cmd_valid = 1'b0;
        `CHK("idle ready", 1'b1, cmd_ready)
        repeat (3) begin
            @(negedge clock);
            `CHK("idle done", 1'b0, done)
        end
        `CHK("idle result", acc_m, result_register)
        `CHK("idle carry", cf_m, carry_flag)
    endtask : t_none

    // Every two-operand op plain, direct and indirect; write-back indirect for odd codes, direct for even
    task automatic t_ops;
        for (int k = 0; k < 3; k++) begin
            for (int op = 3; op < 9; op++) begin
                do_op(4'(op), k[0], 1'(op) ^ k[1], k[0] ? 7'h09 : 7'h05);
                do_op(4'h1, 1'b0, k[1], 7'h09);
            end
        end
    endtask : t_ops

    task automatic test_done;
        if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(negedge clock);
        srst = 1'b0;
        t_build();
        t_none();
        t_ops();
        test_done();
    end

    // Watchdog well beyond the expected run length
    initial begin
        #40000;
        miscompares++;
        test_done();
    end
endmodule : test_nibble_alu_operations
